// ==== gpm_ports.sv ====
// Three general-purpose ports with pin multiplexing and an Avalon-MM register slave.
// Assumes peripherals and the power controller run on the same clock; pins are
// asynchronous and pass a three-stage synchroniser.
`timescale 1ns/1ps

// Functional notes
// - First port: eight pins, each input or output by direction plus function bits.
// - First port pins also carry timer in/out, external and wake-up interrupt inputs.
// - Timer, interrupt and wake-up inputs are all cut off in address-bus setting.
// - Timer inputs are gated off in deep idle and stop modes.
// - External and wake-up interrupt inputs stay open in deep idle and stop.
// - Reset puts the first port in plain input, all control bits cleared.
// - Pins 0, 1 and 4 each feed an external and a wake-up interrupt.
// - Both interrupt sources on a shared pin raise requests independently.
// - Second port: eight pins with per-pin direction and function control.
// - Second port carries two serial channels' tx, rx, cts, clock and CAN tx, rx.
// - Serial and CAN inputs always routed, gated off in deep idle and stop.
// - Reset puts the second port in plain input.
// - Third port is input only; read-only data, no control bits.
// - Third port digital input gates close in deep idle and stop.
module gpm_ports (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // Avalon-MM slave, word addressed
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Interrupt
    output logic             irq,
    // Power mode
    input  wire logic        deep_idle_mode,
    input  wire logic        stop_mode,
    // First port pins
    input  wire logic [7:0]  d_pin_i,
    output logic      [7:0]  d_pin_o,
    output logic      [7:0]  d_pin_oe_n,
    // Second port pins
    input  wire logic [7:0]  f_pin_i,
    output logic      [7:0]  f_pin_o,
    output logic      [7:0]  f_pin_oe_n,
    // Third port pins
    input  wire logic [7:0]  g_pin_i,
    output logic             g_input_gate_open,
    // Timer side
    input  wire logic [3:0]  timer_output,
    output logic      [3:0]  timer_capture_input,
    // Interrupt controller side
    output logic      [2:0]  external_irq_input,
    output logic      [7:0]  wakeup_irq_input,
    // Bus controller side
    input  wire logic [7:0]  upper_address,
    // Serial side
    input  wire logic [1:0]  serial_transmit,
    input  wire logic [1:0]  serial_clock_out,
    output logic      [1:0]  serial_receive,
    output logic      [1:0]  clear_to_send,
    output logic      [1:0]  serial_clock_in,
    // CAN side
    input  wire logic        can_transmit,
    output logic             can_receive
);

    gpm_pkg::gpm_state_s st_q;
    gpm_pkg::gpm_state_s st_d;

    logic       low_power;
    logic       wr_acc;
    logic       rd_acc;
    logic [7:0] d_addr_sel;
    logic [7:0] d_alt;
    logic [7:0] f_alt;
    logic [2:0] ev;

    // ------------------------------------------------------------------
    // Helper terms
    // ------------------------------------------------------------------
    // Deep idle and stop share one gate
    assign low_power  = deep_idle_mode | stop_mode;
    // Request accepted only in the cycle waitrequest is low
    assign wr_acc     = avs_write & ~st_q.wait_n;
    assign rd_acc     = avs_read & ~st_q.wait_n;
    // Pins in address-bus setting
    assign d_addr_sel = ~st_q.d_dir & st_q.d_fn;
    assign d_alt = {timer_output[3], timer_output[2], 2'b00,
                    timer_output[1], timer_output[0], 2'b00};
    assign f_alt = {1'b0, can_transmit, serial_clock_out[1], 1'b0,
                    serial_transmit[1], serial_clock_out[0], 1'b0,
                    serial_transmit[0]};

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // All decisions in one process; outputs are copies of state fields
    always_comb begin
        st_d = st_q;

        // Bus handshake: one wait cycle, then one ready cycle
        st_d.wait_n = ~((avs_read | avs_write) & st_q.wait_n);
        if ((avs_read | avs_write) & st_q.wait_n) begin
            st_d.rdata = 32'h0000_0000;
            if (avs_read) begin
                if (avs_address == gpm_pkg::IDX_D_DATA) begin
                    // Inputs read the pin, outputs read the latch
                    st_d.rdata[7:0] = (st_q.d_dir & st_q.d_data) | (~st_q.d_dir & st_q.d_filt);
                end else if (avs_address == gpm_pkg::IDX_F_DATA) begin
                    st_d.rdata[7:0] = (st_q.f_dir & st_q.f_data) | (~st_q.f_dir & st_q.f_filt);
                end else if (avs_address == gpm_pkg::IDX_G_INPUT) begin
                    st_d.rdata[7:0] = low_power ? 8'h00 : st_q.g_filt;
                end else if (avs_address == gpm_pkg::IDX_IRQ_STAT) begin
                    st_d.rdata[2:0] = st_q.irq_stat;
                end else if (avs_address == gpm_pkg::IDX_IRQ_MASK) begin
                    st_d.rdata[2:0] = st_q.irq_mask;
                end else begin
                    // Write-only control and unmapped words read zero
                    st_d.rdata = 32'h0000_0000;
                end
            end
        end

        // Register writes
        if (wr_acc) begin
            if (avs_address == gpm_pkg::IDX_D_DATA) begin
                st_d.d_data = avs_writedata[7:0];
            end else if (avs_address == gpm_pkg::IDX_D_DIR) begin
                st_d.d_dir = avs_writedata[7:0];
            end else if (avs_address == gpm_pkg::IDX_D_FUNC) begin
                st_d.d_fn = avs_writedata[7:0];
            end else if (avs_address == gpm_pkg::IDX_F_DATA) begin
                st_d.f_data = avs_writedata[7:0];
            end else if (avs_address == gpm_pkg::IDX_F_DIR) begin
                st_d.f_dir = avs_writedata[7:0];
            end else if (avs_address == gpm_pkg::IDX_F_FUNC) begin
                st_d.f_fn = avs_writedata[7:0];
            end else if (avs_address == gpm_pkg::IDX_IRQ_MASK) begin
                st_d.irq_mask = avs_writedata[2:0];
            end
        end

        // Synchronisers; a change counts once stages two and three agree
        st_d.d_s1   = d_pin_i;
        st_d.d_s2   = st_q.d_s1;
        st_d.d_s3   = st_q.d_s2;
        st_d.d_filt = (st_q.d_s2 & st_q.d_s3) | (st_q.d_filt & (st_q.d_s2 | st_q.d_s3));
        st_d.f_s1   = f_pin_i;
        st_d.f_s2   = st_q.f_s1;
        st_d.f_s3   = st_q.f_s2;
        st_d.f_filt = (st_q.f_s2 & st_q.f_s3) | (st_q.f_filt & (st_q.f_s2 | st_q.f_s3));
        st_d.g_s1   = g_pin_i;
        st_d.g_s2   = st_q.g_s1;
        st_d.g_s3   = st_q.g_s2;
        st_d.g_filt = (st_q.g_s2 & st_q.g_s3) | (st_q.g_filt & (st_q.g_s2 | st_q.g_s3));

        // Sticky events: input changes per port; read clears, set wins
        ev[gpm_pkg::IRQ_BIT_D] = |(st_d.d_filt ^ st_q.d_filt);
        ev[gpm_pkg::IRQ_BIT_F] = |(st_d.f_filt ^ st_q.f_filt);
        ev[gpm_pkg::IRQ_BIT_G] = |(st_d.g_filt ^ st_q.g_filt);
        // Clear only what the read reported; a later set survives
        if (rd_acc && avs_address == gpm_pkg::IDX_IRQ_STAT) begin
            st_d.irq_stat = (st_q.irq_stat & ~st_q.rdata[2:0]) | ev;
        end else begin
            st_d.irq_stat = st_q.irq_stat | ev;
        end
        st_d.irq = |(st_d.irq_stat & st_d.irq_mask);

        // First port pin roles by direction and function pair
        for (int i = 0; i < 8; i++) begin
            case ({st_q.d_dir[i], st_q.d_fn[i]})
                2'b10: begin
                    st_d.d_o[i]    = st_q.d_data[i];
                    st_d.d_oe_n[i] = 1'b0;
                end
                2'b01: begin
                    st_d.d_o[i]    = upper_address[i];
                    st_d.d_oe_n[i] = 1'b0;
                end
                2'b11: begin
                    st_d.d_o[i]    = d_alt[i];
                    st_d.d_oe_n[i] = ~gpm_pkg::D_ALT_OUT[i];
                end
                default: begin
                    st_d.d_o[i]    = 1'b0;
                    st_d.d_oe_n[i] = 1'b1;
                end
            endcase
        end

        // Second port pin roles
        for (int i = 0; i < 8; i++) begin
            case ({st_q.f_dir[i], st_q.f_fn[i]})
                2'b10: begin
                    st_d.f_o[i]    = st_q.f_data[i];
                    st_d.f_oe_n[i] = 1'b0;
                end
                2'b11: begin
                    st_d.f_o[i]    = f_alt[i];
                    st_d.f_oe_n[i] = ~gpm_pkg::F_ALT_OUT[i];
                end
                2'b01: begin
                    // Open-drain: drive only a low, release for a high
                    if (gpm_pkg::F_OD_OUT[i]) begin
                        st_d.f_o[i]    = 1'b0;
                        st_d.f_oe_n[i] = f_alt[i];
                    end else begin
                        st_d.f_o[i]    = f_alt[i];
                        st_d.f_oe_n[i] = ~gpm_pkg::F_ALT2_OUT[i];
                    end
                end
                default: begin
                    st_d.f_o[i]    = 1'b0;
                    st_d.f_oe_n[i] = 1'b1;
                end
            endcase
        end

        // First port inputs to peripherals; address setting cuts them off
        st_d.tmr_cap[0] = st_q.d_filt[0] & ~d_addr_sel[0] & ~low_power;
        st_d.tmr_cap[1] = st_q.d_filt[1] & ~d_addr_sel[1] & ~low_power;
        st_d.tmr_cap[2] = st_q.d_filt[4] & ~d_addr_sel[4] & ~low_power;
        st_d.tmr_cap[3] = st_q.d_filt[5] & ~d_addr_sel[5] & ~low_power;
        // Both sources of a shared pin fire; software masks the unwanted one
        st_d.ext_irq[0] = st_q.d_filt[0] & ~d_addr_sel[0];
        st_d.ext_irq[1] = st_q.d_filt[1] & ~d_addr_sel[1];
        st_d.ext_irq[2] = st_q.d_filt[4] & ~d_addr_sel[4];
        st_d.wake       = st_q.d_filt & ~d_addr_sel;

        // Second and third port inputs, closed in low power
        st_d.ser_rx[0]  = st_q.f_filt[1] & ~low_power;
        st_d.ser_rx[1]  = st_q.f_filt[4] & ~low_power;
        st_d.cts[0]     = st_q.f_filt[2] & ~low_power;
        st_d.cts[1]     = st_q.f_filt[5] & ~low_power;
        st_d.sclk_in[0] = st_q.f_filt[2] & ~low_power;
        st_d.sclk_in[1] = st_q.f_filt[5] & ~low_power;
        st_d.can_rx     = st_q.f_filt[7] & ~low_power;
        st_d.g_gate     = ~low_power;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Reset leaves every pin an input with all control bits clear
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_q          <= '0;
            st_q.wait_n   <= 1'b1;
            st_q.d_data   <= gpm_pkg::RST_PORT;
            st_q.d_dir    <= gpm_pkg::RST_PORT;
            st_q.d_fn     <= gpm_pkg::RST_PORT;
            st_q.f_data   <= gpm_pkg::RST_PORT;
            st_q.f_dir    <= gpm_pkg::RST_PORT;
            st_q.f_fn     <= gpm_pkg::RST_PORT;
            st_q.irq_stat <= gpm_pkg::RST_IRQ;
            st_q.irq_mask <= gpm_pkg::RST_IRQ;
            st_q.d_oe_n   <= 8'hFF;
            st_q.f_oe_n   <= 8'hFF;
            st_q.g_gate   <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs straight from state
    // ------------------------------------------------------------------
    assign avs_readdata        = st_q.rdata;
    assign avs_waitrequest     = st_q.wait_n;
    assign irq                 = st_q.irq;
    assign d_pin_o             = st_q.d_o;
    assign d_pin_oe_n          = st_q.d_oe_n;
    assign f_pin_o             = st_q.f_o;
    assign f_pin_oe_n          = st_q.f_oe_n;
    assign g_input_gate_open   = st_q.g_gate;
    assign timer_capture_input = st_q.tmr_cap;
    assign external_irq_input  = st_q.ext_irq;
    assign wakeup_irq_input    = st_q.wake;
    assign serial_receive      = st_q.ser_rx;
    assign clear_to_send       = st_q.cts;
    assign serial_clock_in     = st_q.sclk_in;
    assign can_receive         = st_q.can_rx;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence wait_then_ready;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    bus_handshake_a: assert property ((avs_read | avs_write) && avs_waitrequest
        |=> wait_then_ready)
        else $error("waitrequest did not drop for exactly one cycle");

    plain_input_a: assert property ((st_q.d_dir == 8'h00) && (st_q.d_fn == 8'h00)
        |=> d_pin_oe_n == 8'hFF)
        else $error("first port drives a pin in plain input");

    addr_drive_a: assert property ((d_addr_sel == 8'hFF)
        |=> (d_pin_oe_n == 8'h00) && (d_pin_o == $past(upper_address)))
        else $error("address setting does not drive address lines");

    timer_gate_a: assert property (low_power |=> timer_capture_input == 4'h0)
        else $error("timer input passes in low power");

    wake_open_a: assert property (low_power && (d_addr_sel == 8'h00)
        |=> wakeup_irq_input == $past(st_q.d_filt))
        else $error("wake-up input blocked in low power");

    dual_source_a: assert property ((external_irq_input[0] == wakeup_irq_input[0]) &&
        (external_irq_input[1] == wakeup_irq_input[1]) &&
        (external_irq_input[2] == wakeup_irq_input[4]))
        else $error("shared pin sources disagree");

    serial_gate_a: assert property (low_power
        |=> (serial_receive == 2'b00) && !can_receive && (clear_to_send == 2'b00)
        && (serial_clock_in == 2'b00))
        else $error("serial or CAN input passes in low power");

    analog_gate_a: assert property (low_power |=> !g_input_gate_open)
        else $error("third port gate open in low power");

    wo_read_a: assert property (avs_read && !avs_waitrequest &&
        ((avs_address == gpm_pkg::IDX_D_DIR) || (avs_address == gpm_pkg::IDX_F_FUNC))
        |-> avs_readdata == 32'h0000_0000)
        else $error("write-only register returned data");

    open_drain_a: assert property (!st_q.f_dir[0] && st_q.f_fn[0] && serial_transmit[0]
        |=> f_pin_oe_n[0])
        else $error("open-drain transmit drove a high");

    f_plain_out_a: assert property ((st_q.f_dir == 8'hFF) && (st_q.f_fn == 8'h00)
        |=> (f_pin_oe_n == 8'h00) && (f_pin_o == $past(st_q.f_data)))
        else $error("second port plain output wrong");

    f_input_a: assert property ((st_q.f_dir == 8'h00) && (st_q.f_fn == 8'h00)
        |=> f_pin_oe_n == 8'hFF)
        else $error("second port drives in plain input");

    timer_out_a: assert property ((st_q.d_dir == 8'hFF) && (st_q.d_fn == 8'hFF)
        |=> d_pin_oe_n == ~gpm_pkg::D_ALT_OUT)
        else $error("timer outputs not enabled");

    addr_cut_a: assert property (d_addr_sel[0] |=> !timer_capture_input[0]
        && !external_irq_input[0] && !wakeup_irq_input[0])
        else $error("address pin feeds an input path");

    in_open_a: assert property (!d_addr_sel[1] && !low_power
        |=> timer_capture_input[1] == $past(st_q.d_filt[1]))
        else $error("timer input blocked");

    g_open_a: assert property (!low_power |=> g_input_gate_open)
        else $error("third port gate closed");

    can_tx_a: assert property (st_q.f_dir[6] && st_q.f_fn[6]
        |=> !f_pin_oe_n[6] && (f_pin_o[6] == $past(can_transmit)))
        else $error("CAN transmit not on its pin");

    rx_route_a: assert property (!low_power
        |=> can_receive == $past(st_q.f_filt[7]))
        else $error("CAN receive not routed");

endmodule

// ==== gpm_pkg.sv ====
// Package for the three-port pin multiplexer: register indices, reset values,
// pin role masks and the packed state of the block.
// Assumes a 32-bit Avalon-MM slave whose word address equals the register index.
package gpm_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_D_DATA   = 8'h34;
    localparam logic [7:0] IDX_D_DIR    = 8'h36;
    localparam logic [7:0] IDX_D_FUNC   = 8'h37;
    localparam logic [7:0] IDX_F_DATA   = 8'h3C;
    localparam logic [7:0] IDX_F_DIR    = 8'h3E;
    localparam logic [7:0] IDX_F_FUNC   = 8'h3F;
    localparam logic [7:0] IDX_G_INPUT  = 8'h40;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h44;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h45;

    // ------------------------------------------------------------------
    // Reset values and field layout
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_PORT     = 8'h00;
    localparam logic [2:0] RST_IRQ      = 3'h0;
    localparam int         IRQ_BIT_D    = 0;
    localparam int         IRQ_BIT_F    = 1;
    localparam int         IRQ_BIT_G    = 2;

    // ------------------------------------------------------------------
    // Pin role masks
    // ------------------------------------------------------------------
    localparam logic [7:0] D_ALT_OUT    = 8'hCC;  // Timer outputs on pins 2,3,6,7
    localparam logic [7:0] F_ALT_OUT    = 8'h6D;  // Tx, clock out, CAN tx
    localparam logic [7:0] F_OD_OUT     = 8'h09;  // Open-drain transmit pins
    localparam logic [7:0] F_ALT2_OUT   = 8'h40;  // CAN tx in the other alt setting

    // ------------------------------------------------------------------
    // Whole block state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        wait_n;
        logic [31:0] rdata;
        logic [7:0]  d_data;
        logic [7:0]  d_dir;
        logic [7:0]  d_fn;
        logic [7:0]  f_data;
        logic [7:0]  f_dir;
        logic [7:0]  f_fn;
        logic [2:0]  irq_stat;
        logic [2:0]  irq_mask;
        logic        irq;
        logic [7:0]  d_s1;
        logic [7:0]  d_s2;
        logic [7:0]  d_s3;
        logic [7:0]  d_filt;
        logic [7:0]  f_s1;
        logic [7:0]  f_s2;
        logic [7:0]  f_s3;
        logic [7:0]  f_filt;
        logic [7:0]  g_s1;
        logic [7:0]  g_s2;
        logic [7:0]  g_s3;
        logic [7:0]  g_filt;
        logic [7:0]  d_o;
        logic [7:0]  d_oe_n;
        logic [7:0]  f_o;
        logic [7:0]  f_oe_n;
        logic [3:0]  tmr_cap;
        logic [2:0]  ext_irq;
        logic [7:0]  wake;
        logic [1:0]  ser_rx;
        logic [1:0]  cts;
        logic [1:0]  sclk_in;
        logic        can_rx;
        logic        g_gate;
    } gpm_state_s;

endpackage

// ==== gpm_pad_model.sv ====
// Pad model for one eight-pin port: external drivers plus pull-ups.
// Assumes the device drives a pad while its output enable is low.
`timescale 1ns/1ps
module gpm_pad_model (
    // Device side
    input  wire logic [7:0] dev_o,
    input  wire logic [7:0] dev_oe_n,
    // Board side
    input  wire logic [7:0] ext_v,
    input  wire logic [7:0] ext_en,
    // Resolved level
    output logic      [7:0] pad
);
    // Device wins, then an enabled board driver; released lines with no board driver float up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pad[i] = !dev_oe_n[i] ? dev_o[i] : (ext_en[i] ? ext_v[i] : 1'b1);
        end
    end
endmodule

// ==== gpm_ports_tb.sv ====
// Self-checking bench for the three-port pin multiplexer.
// Assumes one 10 MHz clock and word-addressed Avalon-MM registers.
`timescale 1ns/1ps
module gpm_ports_tb;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        clock, rstn, avs_read, avs_write, avs_waitrequest, irq;
    logic [7:0]  avs_address, d_pin_i, d_pin_o, d_pin_oe_n, f_pin_i, f_pin_o, f_pin_oe_n;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic        deep_idle_mode, stop_mode, g_input_gate_open, can_transmit, can_receive;
    logic [7:0]  g_pin_i, wakeup_irq_input, upper_address, d_ext, f_ext;
    logic [3:0]  timer_output, timer_capture_input;
    logic [2:0]  external_irq_input;
    logic [1:0]  serial_transmit, serial_clock_out, serial_receive, clear_to_send;
    logic [1:0]  serial_clock_in;
    int          fails, total_checks;

    // ------------------------------------------------------------------
    // Design, pads and clock
    // ------------------------------------------------------------------
    gpm_ports u_dut (.clock(clock), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
        .deep_idle_mode(deep_idle_mode), .stop_mode(stop_mode), .d_pin_i(d_pin_i),
        .d_pin_o(d_pin_o), .d_pin_oe_n(d_pin_oe_n), .f_pin_i(f_pin_i), .f_pin_o(f_pin_o),
        .f_pin_oe_n(f_pin_oe_n), .g_pin_i(g_pin_i), .g_input_gate_open(g_input_gate_open),
        .timer_output(timer_output), .timer_capture_input(timer_capture_input),
        .external_irq_input(external_irq_input), .wakeup_irq_input(wakeup_irq_input),
        .upper_address(upper_address), .serial_transmit(serial_transmit),
        .serial_clock_out(serial_clock_out), .serial_receive(serial_receive),
        .clear_to_send(clear_to_send), .serial_clock_in(serial_clock_in),
        .can_transmit(can_transmit), .can_receive(can_receive));
    gpm_pad_model u_dpad (.dev_o(d_pin_o), .dev_oe_n(d_pin_oe_n), .ext_v(d_ext),
        .ext_en(8'hFF), .pad(d_pin_i));
    gpm_pad_model u_fpad (.dev_o(f_pin_o), .dev_oe_n(f_pin_oe_n), .ext_v(f_ext),
        .ext_en(8'hFF), .pad(f_pin_i));
    // Free-running system clock
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    // One bus access; held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= wd;
        avs_read <= !wr;
        avs_write <= wr;
        @(posedge clock);
        while (avs_waitrequest !== 1'b0 && n < 50) begin
            @(posedge clock);
            n++;
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) fails++;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    // Pins need five edges through the filter; one spare
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        chk(d_pin_oe_n, 8'hFF, "d plain input");
        chk(f_pin_oe_n, 8'hFF, "f plain input");
        bus(1'b0, gpm_pkg::IDX_D_DATA, 0); chk(rd, 0, "d data");
        bus(1'b0, gpm_pkg::IDX_D_DIR, 0); chk(rd, 0, "d dir hidden");
        bus(1'b0, gpm_pkg::IDX_F_FUNC, 0); chk(rd, 0, "f func hidden");
        bus(1'b0, 8'h50, 0); chk(rd, 0, "unmapped");
        $display("done reset");
    endtask
    task automatic t_dport;
        bus(1'b1, gpm_pkg::IDX_D_DATA, 32'hA5);
        bus(1'b1, gpm_pkg::IDX_D_DIR, 32'hFF);
        tick(2); chk(d_pin_oe_n, 8'h00, "d out en");
        chk(d_pin_o, 8'hA5, "d out");
        bus(1'b0, gpm_pkg::IDX_D_DATA, 0); chk(rd, 32'hA5, "d latch");
        timer_output <= 4'hA;
        bus(1'b1, gpm_pkg::IDX_D_FUNC, 32'hFF);
        tick(3); chk(d_pin_oe_n, 8'h33, "timer out en");
        chk(d_pin_o & 8'hCC, 8'h88, "timer out");
        bus(1'b1, gpm_pkg::IDX_D_DIR, 32'h00);
        tick(6); chk(d_pin_o, 8'h33, "address out");
        chk(d_pin_oe_n, 8'h00, "address en");
        chk({timer_capture_input, external_irq_input, wakeup_irq_input}, 0, "addr cut");
        $display("done first port");
    endtask
    task automatic t_fport;
        f_ext <= 8'hB6;
        tick(6); chk({serial_receive, clear_to_send, serial_clock_in, can_receive},
                     7'h7F, "f inputs");
        serial_transmit <= 2'b01; serial_clock_out <= 2'b10; can_transmit <= 1'b1;
        bus(1'b1, gpm_pkg::IDX_F_DIR, 32'hFF);
        bus(1'b1, gpm_pkg::IDX_F_FUNC, 32'hFF);
        tick(3); chk(f_pin_oe_n, 8'h92, "f alt en");
        chk(f_pin_o & 8'h6D, 8'h61, "f alt out");
        bus(1'b1, gpm_pkg::IDX_F_DIR, 32'h00);
        tick(3); chk(f_pin_oe_n, 8'hB7, "open drain en");
        chk({f_pin_o[3], f_pin_o[0]}, 2'b00, "open drain low");
        bus(1'b1, gpm_pkg::IDX_F_DATA, 32'h5A);
        bus(1'b1, gpm_pkg::IDX_F_DIR, 32'hFF);
        bus(1'b1, gpm_pkg::IDX_F_FUNC, 32'h00);
        tick(3); chk({f_pin_oe_n, f_pin_o}, 16'h005A, "f plain out");
        $display("done second port");
    endtask
    task automatic t_lowpow;
        d_ext <= 8'h33;
        bus(1'b1, gpm_pkg::IDX_IRQ_MASK, 32'h0);
        bus(1'b1, gpm_pkg::IDX_D_FUNC, 32'h00);
        bus(1'b1, gpm_pkg::IDX_F_DIR, 32'h00);
        bus(1'b1, gpm_pkg::IDX_G_INPUT, 32'hFF);
        tick(6); chk(timer_capture_input, 4'hF, "capture");
        chk({external_irq_input, wakeup_irq_input}, 11'h733, "both sources");
        bus(1'b0, gpm_pkg::IDX_G_INPUT, 0); chk(rd, 32'h3C, "g read only");
        for (int m = 0; m < 2; m++) begin
            deep_idle_mode <= (m == 0);
            stop_mode <= (m == 1);
            tick(3); chk(timer_capture_input, 0, "capture gated");
            chk({external_irq_input, wakeup_irq_input}, 11'h733, "irq open");
            chk({serial_receive, clear_to_send, serial_clock_in, can_receive}, 0, "f gated");
            chk(g_input_gate_open, 1'b0, "g gate");
            bus(1'b0, gpm_pkg::IDX_G_INPUT, 0); chk(rd, 0, "g gated");
        end
        deep_idle_mode <= 1'b0;
        stop_mode <= 1'b0;
        tick(6); chk(g_input_gate_open, 1'b1, "g reopened");
        $display("done low power");
    endtask
    task automatic t_irq;
        bus(1'b0, gpm_pkg::IDX_IRQ_STAT, 0);
        bus(1'b1, gpm_pkg::IDX_IRQ_MASK, 32'h4);
        bus(1'b0, gpm_pkg::IDX_IRQ_MASK, 0); chk(rd, 32'h4, "mask read");
        g_pin_i <= 8'hC3;
        tick(8); chk(irq, 1'b1, "irq raised");
        bus(1'b0, gpm_pkg::IDX_IRQ_STAT, 0); chk(rd, 32'h4, "status");
        tick(2); chk(irq, 1'b0, "irq cleared");
        d_ext <= 8'h00;
        tick(8); chk(irq, 1'b0, "irq masked");
        bus(1'b0, gpm_pkg::IDX_IRQ_STAT, 0); chk(rd, 32'h1, "masked status");
        $display("done interrupts");
    endtask

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        fails = 0; total_checks = 0; rstn = 1'b0; avs_read = 1'b0; avs_write = 1'b0;
        avs_address = 8'h00; avs_writedata = 32'h0; deep_idle_mode = 1'b0;
        stop_mode = 1'b0; g_pin_i = 8'h3C; d_ext = 8'h00; f_ext = 8'h00;
        timer_output = 4'h0; upper_address = 8'h33; serial_transmit = 2'b00;
        serial_clock_out = 2'b00; can_transmit = 1'b0;
        tick(3);
        rstn <= 1'b1;
        tick(8);
        t_reset; t_dport; t_fport; t_lowpow; t_irq;
        tally_and_finish;
    end
    // Whole run needs some 150 cycles; give it twenty times that
    initial begin
        #300000;
        fails++;
        tally_and_finish;
    end
endmodule
